// File: rtl/dao_top.sv
`timescale 1ns/10ps
`include "dao_map.svh"
module dao_top #(
  parameter int QTR_CYCLES = `DAO_QTR_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic [1:0]            door_open_pin,
  input  wire logic [1:0]            exit_btn_pin,
  input  wire logic [1:0]            aux_zero_v_pin,
  input  wire logic [1:0]            guest_key_pin,
  input  wire logic                  tamper_pin,
  input  wire logic                  mains_fail_pin,
  input  wire logic                  door_offline_pin,
  input  wire dao_pkg::dao_door_cfg_s door_cfg [2],
  input  wire dao_pkg::dao_alt_s      alt_cfg,
  input  wire dao_pkg::dao_req_s      req,
  input  wire logic [1:0]            aux_normal,
  input  wire logic [1:0]            oc_a_normal,
  input  wire logic [1:0]            oc_b_normal,
  input  wire logic                  antipassback_en,
  input  wire logic                  user_limit_en,
  input  wire logic [11:0]           limit_a,
  input  wire logic [11:0]           limit_b,
  input  wire logic [3:0]            pin_len_cfg,
  input  wire logic [10:0]           time_of_day_min,
  input  wire logic [10:0]           reset_time_min,
  input  wire logic                  daily_reset_en,
  input  wire logic                  manual_reset,
  output logic [1:0]                 relay_out_ff,
  output logic [1:0]                 buzzer_ff,
  output logic [1:0]                 aux_relay_ff,
  output logic [1:0]                 open_collector_out_a_ff,
  output logic [1:0]                 open_collector_out_b_ff,
  output logic                       grant_ff,
  output logic                       deny_ff,
  output logic                       result_door_ff,
  output logic [11:0]                user_count_ff,
  output logic                       track_reset_log_ff,
  output logic                       track_busy_ff,
  output logic [3:0]                 pin_len_ff,
  output logic [3:0]                 admin_len_ff,
  output logic [3:0]                 admin_zeros_ff
);

  // ====================================================================
  // Reset release and pin synchronisers
  // ====================================================================
  logic        rst_meta_ff;
  logic        rst_n_sync;
  logic [10:0] pins_s;
  logic [1:0]  door_open;
  logic [1:0]  exit_btn;
  logic [1:0]  aux_zv;
  logic [1:0]  guest_key;
  logic        fault;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_sync  <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_sync  <= rst_meta_ff;
    end
  end

  dao_sync #(.W(11)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_sync),
    .din     ({tamper_pin, mains_fail_pin, door_offline_pin, guest_key_pin,
                aux_zero_v_pin, exit_btn_pin, door_open_pin}),
    .dout    (pins_s)
  );

  assign door_open = pins_s[1:0];
  assign exit_btn  = pins_s[3:2];
  assign aux_zv    = pins_s[5:4];
  assign guest_key = pins_s[7:6];
  assign fault     = |pins_s[10:8];

  logic [1:0] open_d_ff;
  logic [1:0] exit_d_ff;
  logic [1:0] guest_d_ff;

  always_ff @(posedge clk_sys or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      open_d_ff  <= 2'h0;
      exit_d_ff  <= 2'h0;
      guest_d_ff <= 2'h0;
    end
    else
    begin
      open_d_ff  <= door_open;
      exit_d_ff  <= exit_btn;
      guest_d_ff <= guest_key;
    end
  end

  // ====================================================================
  // Quarter-second tick
  // ====================================================================
  logic [23:0] qtr_cnt_ff;
  logic        qtr_tick;

  assign qtr_tick = (qtr_cnt_ff == 24'(QTR_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      qtr_cnt_ff <= 24'h0;
    else if (qtr_tick)
      qtr_cnt_ff <= 24'h0;
    else
      qtr_cnt_ff <= qtr_cnt_ff + 24'h1;
  end

  // ====================================================================
  // Access decision and user tracking
  // ====================================================================
  logic        user_in_mem [0:`DAO_USERS-1];
  logic [10:0] clr_idx_ff;
  logic        user_in;
  logic        lim_full;
  logic        grant;
  logic        entry_trk;
  logic        day_hit;
  logic [10:0] tod_d_ff;

  function automatic logic [11:0] max12(input logic [11:0] a, input logic [11:0] b);
    max12 = (a > b) ? a : b;
  endfunction : max12

  assign user_in   = user_in_mem[req.user];
  assign lim_full  = (user_count_ff >= max12(limit_a, limit_b));
  assign entry_trk = req.tracked && !req.is_exit;
  assign day_hit   = daily_reset_en && (time_of_day_min == reset_time_min) &&
                     (tod_d_ff != time_of_day_min);
  assign grant = req.valid && !track_busy_ff && req.card_ok &&
                 (req.tz_ok || (req.is_exit && door_cfg[req.door].exit_always)) && // [R05]
                 !(entry_trk && antipassback_en && user_in) &&                      // [R20]
                 !(entry_trk && user_limit_en && lim_full);                         // [R21]

  always_ff @(posedge clk_sys or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      grant_ff       <= 1'b0;
      deny_ff        <= 1'b0;
      result_door_ff <= 1'b0;
    end
    else
    begin
      grant_ff       <= grant;
      deny_ff        <= req.valid && !grant;
      result_door_ff <= req.door;
    end
  end

  // Sweep clears every user; decisions are refused meanwhile
  always_ff @(posedge clk_sys or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      track_busy_ff      <= 1'b1;
      clr_idx_ff         <= 11'h0;
      tod_d_ff           <= 11'h0;
      track_reset_log_ff <= 1'b0;
    end
    else
    begin
      tod_d_ff           <= time_of_day_min;
      track_reset_log_ff <= day_hit || manual_reset; // [R22]
      if (day_hit || manual_reset)
      begin
        track_busy_ff <= 1'b1;
        clr_idx_ff    <= 11'h0;
      end
      else if (track_busy_ff)
      begin
        clr_idx_ff <= clr_idx_ff + 11'h1;
        if (clr_idx_ff == 11'h7FF)
          track_busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (track_busy_ff)
      user_in_mem[clr_idx_ff] <= 1'b0; // [R22]
    else if (grant && req.tracked)
      user_in_mem[req.user] <= !req.is_exit;
  end

  always_ff @(posedge clk_sys or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      user_count_ff <= 12'h0;
    else if (day_hit || manual_reset)
      user_count_ff <= 12'h0; // [R22]
    else if (grant && entry_trk && !user_in)
      user_count_ff <= user_count_ff + 12'h1; // [R23]
    else if (grant && req.tracked && req.is_exit && user_in && user_count_ff != 12'h0)
      user_count_ff <= user_count_ff - 12'h1; // [R23]
  end

  // ====================================================================
  // Per-door relay, release and buzzer
  // ====================================================================
  logic [1:0]  release_ff;
  logic        fire_act;

  assign fire_act = !aux_zv[0]; // [R11]

  for (genvar d = 0; d < `DAO_NUM_DOORS; d++)
  begin : g_door
    logic [11:0] relay_cnt_ff;
    logic        start;
    logic        nxt_release;
    logic        beep;
    logic        guest;

    assign start = (grant_ff && result_door_ff == 1'(d)) ||
                   (door_cfg[d].push_button_en && exit_btn[d] && !exit_d_ff[d]); // [R01]

    always_ff @(posedge clk_sys or negedge rst_n_sync)
    begin
      if (!rst_n_sync)
        relay_cnt_ff <= 12'h0;
      else if (start)
        relay_cnt_ff <= (door_cfg[d].relay_time == 10'h0) ? 12'(`DAO_RELAY0_QTR) :
                        12'({door_cfg[d].relay_time, 2'b00});
      else if (door_cfg[d].locksaver && door_open[d])
        relay_cnt_ff <= 12'h0; // [R02]
      else if (qtr_tick && relay_cnt_ff != 12'h0)
        relay_cnt_ff <= relay_cnt_ff - 12'h1;
    end

    assign nxt_release = (door_cfg[d].fire_select && fire_act) ||                      // [R11]
                         (!(door_cfg[d].interlock && aux_zv[d]) &&                     // [R06]
                          ((relay_cnt_ff != 12'h0) ||
                           (door_cfg[d].presence_exit_hold && exit_btn[d])));          // [R09]

    always_ff @(posedge clk_sys or negedge rst_n_sync)
    begin
      if (!rst_n_sync)
      begin
        release_ff[d]   <= 1'b0;
        relay_out_ff[d] <= 1'b0;
        buzzer_ff[d]    <= 1'b0;
      end
      else
      begin
        release_ff[d]   <= nxt_release;
        relay_out_ff[d] <= release_ff[d] ^ door_cfg[d].failsafe; // [R10]
        buzzer_ff[d]    <= beep || guest;
      end
    end

    dao_pulse u_beep (
      .clk_sys (clk_sys),
      .rst_n   (rst_n_sync),
      .start   ((door_cfg[d].chime && door_open[d] && !open_d_ff[d]) ||     // [R03]
                ((grant_ff || deny_ff) && result_door_ff == 1'(d) &&
                 !door_cfg[d].silent)),                                     // [R08]
      .tick    (qtr_tick),
      .len     (4'(`DAO_CHIME_QTR)),
      .active  (beep)
    );

    dao_pulse u_guest (
      .clk_sys (clk_sys),
      .rst_n   (rst_n_sync),
      .start   (door_cfg[d].guest_call && guest_key[d] && !guest_d_ff[d]), // [R04]
      .tick    (qtr_tick),
      .len     (4'(`DAO_GUEST_QTR)),
      .active  (guest)
    );
  end

  // ====================================================================
  // Outputs with alternate functions
  // ====================================================================
  function automatic logic oc_b_sel(input logic il, input logic open, input logic rel,
                                    input logic norm);
    oc_b_sel = il ? (open || rel) : norm; // [R07]
  endfunction : oc_b_sel

  always_ff @(posedge clk_sys or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      aux_relay_ff            <= 2'h0;
      open_collector_out_a_ff <= 2'h0;
      open_collector_out_b_ff <= 2'h0;
    end
    else
    begin
      aux_relay_ff[0] <= alt_cfg.aux_any ? |aux_normal : aux_normal[0]; // [R16]
      aux_relay_ff[1] <= alt_cfg.users_present ? (user_count_ff != 12'h0) :
                         aux_normal[1]; // [R17]
      open_collector_out_a_ff[0] <= alt_cfg.tech_fault ? fault : oc_a_normal[0]; // [R14]
      open_collector_out_a_ff[1] <= alt_cfg.limit_a ? (user_count_ff < limit_a) :
                                    oc_a_normal[1]; // [R18]
      open_collector_out_b_ff[0] <= alt_cfg.any_open ? |door_open : // [R15]
        oc_b_sel(door_cfg[0].interlock, door_open[0], release_ff[0], oc_b_normal[0]);
      open_collector_out_b_ff[1] <= alt_cfg.limit_b ? (user_count_ff < limit_b) : // [R19]
        oc_b_sel(door_cfg[1].interlock, door_open[1], release_ff[1], oc_b_normal[1]);
    end
  end

  // ====================================================================
  // PIN length
  // ====================================================================
  always_ff @(posedge clk_sys or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      pin_len_ff     <= 4'(`DAO_PIN_MIN);
      admin_len_ff   <= 4'(`DAO_ADMIN_LEN);
      admin_zeros_ff <= 4'h0;
    end
    else
    begin
      if (pin_len_cfg >= 4'(`DAO_PIN_MIN) && pin_len_cfg <= 4'(`DAO_PIN_MAX))
        pin_len_ff <= pin_len_cfg; // [R12]
      admin_len_ff   <= (pin_len_ff > 4'(`DAO_ADMIN_LEN)) ? pin_len_ff :
                        4'(`DAO_ADMIN_LEN); // [R13]
      admin_zeros_ff <= (pin_len_ff > 4'(`DAO_ADMIN_LEN)) ?
                        (pin_len_ff - 4'(`DAO_ADMIN_LEN)) : 4'h0; // [R13]
    end
  end

  // ====================================================================
  // Checks
  // ====================================================================
  AST_PB_START: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R01]
    (door_cfg[0].push_button_en && exit_btn[0] && !exit_d_ff[0])
      |=> (g_door[0].relay_cnt_ff != 12'h0))
    else $error("push button did not start relay");
  AST_LOCKSAVER: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R02]
    (door_cfg[0].locksaver && door_open[0] && !g_door[0].start)
      |=> (g_door[0].relay_cnt_ff == 12'h0))
    else $error("relay timer not truncated");
  AST_GUEST: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R04]
    (door_cfg[0].guest_call && guest_key[0] && !guest_d_ff[0])
      |=> ##1 buzzer_ff[0] [*8])
    else $error("guest buzzer too short");
  AST_FIRE: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R11]
    (fire_act && door_cfg[1].fire_select) |=> release_ff[1])
    else $error("fire door not released");
  AST_INTERLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R06]
    (door_cfg[1].interlock && aux_zv[1] && !(fire_act && door_cfg[1].fire_select))
      |=> !release_ff[1])
    else $error("interlocked door released");
  AST_FAILSAFE: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R10]
    (door_cfg[0].failsafe && !release_ff[0] && $stable(door_cfg[0].failsafe))
      |=> relay_out_ff[0])
    else $error("failsafe relay not energised while locked");
  AST_USERS: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R17]
    (alt_cfg.users_present && user_count_ff != 12'h0) |=> aux_relay_ff[1])
    else $error("users present output missing");
  AST_LIMIT_A: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R18]
    (alt_cfg.limit_a && user_count_ff >= limit_a) |=> !open_collector_out_a_ff[1])
    else $error("limit A output still on");
  AST_PASSBACK: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R20]
    (req.valid && entry_trk && antipassback_en && user_in) |=> (deny_ff && !grant_ff))
    else $error("passback entry granted");
  AST_LIMIT: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R21]
    (req.valid && entry_trk && user_limit_en && lim_full) |=> !grant_ff)
    else $error("entry over user limit");
  AST_FLOOR: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R23]
    (user_count_ff == 12'h0 && !(grant && entry_trk)) |=> (user_count_ff == 12'h0))
    else $error("user count moved below zero");
  AST_ANY_OPEN: assert property (@(posedge clk_sys) disable iff (!rst_n_sync) // [R15]
    (alt_cfg.any_open && door_open[1]) |=> open_collector_out_b_ff[0])
    else $error("any door open output missing");
endmodule : dao_top

// File: rtl/dao_map.svh
// Operation
// R01 - Push-button option, on by default, energises door relay when exit button closes.
// R02 - Anti-tailgate option cuts relay timer short once the door opens.
// R03 - Chime option pulses buzzer briefly when door goes closed to open.
// R04 - Guest-call option drives buzzer for 2 seconds after keypad guest key.
// R05 - Always-exit option grants exit to valid enabled cards ignoring timezones.
// R06 - Interlock option blocks door release while auxiliary input is active.
// R07 - With interlock, second open-collector output follows door open or relay energised.
// R08 - Silent option keeps buzzer off on granted and denied outcomes.
// R09 - Presence-exit hold keeps door released while exit contact stays closed.
// R10 - Failsafe option inverts relay so it is energised while locked.
// R11 - Door 1 aux input losing 0V holds fire-selected doors released until restored.
// R12 - Configured PIN length accepted from 4 through 9 digits.
// R13 - PIN length above six extends operator and installer codes with leading zeros.
// R14 - Tech-fault function: door 1 first output on tamper, mains fail or offline.
// R15 - Any-door-open function: door 1 second output while any door is open.
// R16 - Any-door function: aux relay 1 on while any door aux relay is on.
// R17 - Users-present function: aux relay 2 on while logged-in count is nonzero.
// R18 - Limit-A function: door 2 first output off while count at or above A.
// R19 - Limit-B function: door 2 second output off while count at or above B.
// R20 - Anti-passback: entry allowed only if the user's last movement was exit.
// R21 - User limiting denies tracked entries once count reaches larger of A and B.
// R22 - Daily time or manual request logs all users out and records it.
// R23 - Count rises on granted tracked entry, falls on tracked exit, never below zero.
`ifndef DAO_MAP_SVH
`define DAO_MAP_SVH
`define DAO_NUM_DOORS   2
`define DAO_CLK_HZ      50000000
`define DAO_QTR_MS      250
`define DAO_QTR_CYCLES  ((`DAO_CLK_HZ / 1000) * `DAO_QTR_MS)
`define DAO_QTR_PER_S   4
`define DAO_GUEST_S     2
`define DAO_GUEST_QTR   (`DAO_GUEST_S * `DAO_QTR_PER_S)
`define DAO_CHIME_QTR   1
`define DAO_RELAY0_QTR  1
`define DAO_PIN_MIN     4
`define DAO_PIN_MAX     9
`define DAO_ADMIN_LEN   6
`define DAO_USERS       2048
`define DAO_UIDX_W      11
`define DAO_CNT_W       12
`define DAO_PB_DEFAULT  1
`endif

// File: rtl/dao_pkg.sv
package dao_pkg;
  typedef struct packed {
    logic       push_button_en;
    logic       locksaver;
    logic       chime;
    logic       guest_call;
    logic       exit_always;
    logic       interlock;
    logic       silent;
    logic       presence_exit_hold;
    logic       failsafe;
    logic       fire_select;
    logic [9:0] relay_time;
  } dao_door_cfg_s;

  typedef struct packed {
    logic        valid;
    logic        door;
    logic [10:0] user;
    logic        card_ok;
    logic        tz_ok;
    logic        is_exit;
    logic        tracked;
  } dao_req_s;

  typedef struct packed {
    logic tech_fault;
    logic any_open;
    logic aux_any;
    logic users_present;
    logic limit_a;
    logic limit_b;
  } dao_alt_s;
endpackage : dao_pkg

// File: rtl/dao_sync.sv
`timescale 1ns/10ps
module dao_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      dout    <= '0;
    end
    else
    begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : dao_sync

// File: rtl/dao_pulse.sv
`timescale 1ns/10ps
module dao_pulse (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic       tick,
  input  wire logic [3:0] len,
  output logic            active
);
  logic [3:0] cnt_ff;

  // Start wins over an expiring count
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= 4'h0;
    else if (start)
      cnt_ff <= len;
    else if (tick && cnt_ff != 4'h0)
      cnt_ff <= cnt_ff - 4'h1;
  end

  assign active = (cnt_ff != 4'h0);
endmodule : dao_pulse

// File: testbench/dao_door_model.sv
`timescale 1ns/10ps
// ==========================================
// Door contact and exit button of two doors
module dao_door_model (
  input  wire logic       clk_sys,
  input  wire logic [1:0] open_cmd,
  input  wire logic [1:0] press_cmd,
  output logic      [1:0] door_open_pin,
  output logic      [1:0] exit_btn_pin
);
  initial
  begin
    door_open_pin = 2'h0;
    exit_btn_pin  = 2'h0;
  end

  // Contacts change only between clock edges
  always @(negedge clk_sys)
  begin
    door_open_pin <= open_cmd;
    exit_btn_pin  <= press_cmd;
  end
endmodule : dao_door_model

// File: testbench/dao_top_test.sv
`timescale 1ns/10ps
module dao_top_test;
  logic                   clk_sys, reset_n, tamper_pin, manual_reset, apb_en, ulim_en;
  logic [1:0]             open_cmd, press_cmd, door_open_pin, exit_btn_pin, aux_zero_v_pin;
  logic [1:0]             guest_key_pin, aux_normal, oc_a_norm, oc_b_norm;
  dao_pkg::dao_door_cfg_s cfg [2];
  dao_pkg::dao_alt_s      alt_cfg;
  dao_pkg::dao_req_s      req;
  logic [11:0]            limit_a, limit_b, count;
  logic [3:0]             pin_len_cfg, pin_len, admin_len, admin_zeros;
  logic [1:0]             relay, buzz, aux_relay, oc_a, oc_b;
  logic                   grant, deny, log_p, busy, mains_fail;
  int                     n_mismatch = 0;
  int                     comparisons = 0;

  dao_door_model dao_door_model_i (.clk_sys(clk_sys), .open_cmd(open_cmd),
    .press_cmd(press_cmd), .door_open_pin(door_open_pin), .exit_btn_pin(exit_btn_pin));

  dao_top #(.QTR_CYCLES(4)) dao_top_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .door_open_pin(door_open_pin), .exit_btn_pin(exit_btn_pin),
    .aux_zero_v_pin(aux_zero_v_pin), .guest_key_pin(guest_key_pin), .tamper_pin(tamper_pin),
    .mains_fail_pin(mains_fail), .door_offline_pin(1'b0), .door_cfg(cfg), .alt_cfg(alt_cfg),
    .req(req), .aux_normal(aux_normal), .oc_a_normal(oc_a_norm), .oc_b_normal(oc_b_norm),
    .antipassback_en(apb_en), .user_limit_en(ulim_en), .limit_a(limit_a), .limit_b(limit_b),
    .pin_len_cfg(pin_len_cfg), .time_of_day_min(11'h000), .reset_time_min(11'h3FF),
    .daily_reset_en(1'b0), .manual_reset(manual_reset), .relay_out_ff(relay),
    .buzzer_ff(buzz), .aux_relay_ff(aux_relay), .open_collector_out_a_ff(oc_a),
    .open_collector_out_b_ff(oc_b), .grant_ff(grant), .deny_ff(deny), .result_door_ff(),
    .user_count_ff(count), .track_reset_log_ff(log_p), .track_busy_ff(busy),
    .pin_len_ff(pin_len), .admin_len_ff(admin_len), .admin_zeros_ff(admin_zeros));

  // ==========================================
  // Shared helpers
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic wait_idle;
    for (int i = 0; i < 2200 && busy !== 1'b0; i++) @(negedge clk_sys);
    check("busy", 12'h0, {11'h0, busy});
  endtask : wait_idle

  task automatic buzz_len(input int d, input int win, output int n);
    n = 0;
    repeat (win)
    begin
      @(negedge clk_sys);
      if (buzz[d] === 1'b1) n++;
    end
  endtask : buzz_len

  task automatic do_req(input logic d, input logic [10:0] u, input logic ex, input logic tz,
                        input logic exp);
    req = '0;
    req.valid = 1'b1;
    req.door = d;
    req.user = u;
    req.card_ok = 1'b1;
    req.tz_ok = tz;
    req.is_exit = ex;
    req.tracked = 1'b1;
    @(negedge clk_sys);
    req.valid = 1'b0;
    for (int i = 0; i < 3 && grant !== 1'b1 && deny !== 1'b1; i++) @(negedge clk_sys);
    check("grant", {11'h0, exp}, {11'h0, grant});
    cyc(2);
  endtask : do_req

  // ==========================================
  // Scenarios
  task automatic t_pin;
    logic [3:0] cf [4] = '{4'h7, 4'hA, 4'h9, 4'h4};
    logic [3:0] ln [4] = '{4'h7, 4'h7, 4'h9, 4'h4};
    for (int i = 0; i < 4; i++)
    begin
      pin_len_cfg = cf[i];
      cyc(4);
      check("pin_len", {8'h0, ln[i]}, {8'h0, pin_len});
      check("admin_len", (ln[i] > 6) ? ln[i] : 12'h6, {8'h0, admin_len});
      check("admin_zeros", (ln[i] > 6) ? ln[i] - 6 : 12'h0, {8'h0, admin_zeros});
    end
    $display("pin length test done");
  endtask : t_pin

  task automatic t_door;
    cfg[0].relay_time = 10'h002;
    press_cmd = 2'h1;
    cyc(8);
    check("relay pb", 12'h1, {11'h0, relay[0]});
    press_cmd = 2'h0;
    cyc(12);
    cfg[0].locksaver = 1'b1;
    press_cmd = 2'h1;
    cyc(8);
    open_cmd = 2'h1;
    press_cmd = 2'h0;
    cyc(8);
    check("relay locksaver", 12'h0, {11'h0, relay[0]});
    open_cmd = 2'h0;
    cfg[0].presence_exit_hold = 1'b1;
    cyc(10);
    press_cmd = 2'h1;
    cyc(40);
    check("relay hold", 12'h1, {11'h0, relay[0]});
    press_cmd = 2'h0;
    cfg[0] = '0;
    cfg[0].push_button_en = 1'b1;
    cyc(12);
    cfg[0].failsafe = 1'b1;
    cyc(4);
    check("relay failsafe", 12'h1, {11'h0, relay[0]});
    cfg[0].failsafe = 1'b0;
    $display("door relay test done");
  endtask : t_door

  task automatic t_buzz;
    int n;
    cfg[0].chime = 1'b1;
    cyc(4);
    open_cmd = 2'h1;
    buzz_len(0, 20, n);
    check("chime", 12'h1, {11'h0, n inside {[1:4]}});
    open_cmd = 2'h0;
    cfg[0].guest_call = 1'b1;
    cyc(12);
    guest_key_pin = 2'h1;
    buzz_len(0, 50, n);
    check("guest", 12'h1, {11'h0, n inside {[28:36]}});
    guest_key_pin = 2'h0;
    cfg[0].silent = 1'b1;
    cyc(4);
    do_req(1'b0, 11'h003, 1'b1, 1'b1, 1'b1);
    buzz_len(0, 16, n);
    check("silent", 12'h0, n[11:0]);
    cfg[0] = '0;
    cfg[0].push_button_en = 1'b1;
    $display("buzzer test done");
  endtask : t_buzz

  task automatic t_track;
    apb_en = 1'b1;
    ulim_en = 1'b1;
    limit_a = 12'h1;
    limit_b = 12'h2;
    alt_cfg = '0;
    alt_cfg.users_present = 1'b1;
    alt_cfg.limit_a = 1'b1;
    alt_cfg.limit_b = 1'b1;
    do_req(1'b1, 11'h005, 1'b0, 1'b1, 1'b1);
    check("count", 12'h1, count);
    check("aux users", 12'h1, {11'h0, aux_relay[1]});
    check("limit a", 12'h0, {11'h0, oc_a[1]});
    check("limit b", 12'h1, {11'h0, oc_b[1]});
    do_req(1'b1, 11'h005, 1'b0, 1'b1, 1'b0);
    do_req(1'b1, 11'h006, 1'b0, 1'b1, 1'b1);
    check("limit b full", 12'h0, {11'h0, oc_b[1]});
    do_req(1'b1, 11'h007, 1'b0, 1'b1, 1'b0);
    do_req(1'b1, 11'h005, 1'b1, 1'b1, 1'b1);
    do_req(1'b1, 11'h009, 1'b1, 1'b1, 1'b1);
    check("count", 12'h1, count);
    do_req(1'b0, 11'h00A, 1'b1, 1'b0, 1'b0);
    cfg[0].exit_always = 1'b1;
    do_req(1'b0, 11'h00A, 1'b1, 1'b0, 1'b1);
    do_req(1'b0, 11'h00A, 1'b0, 1'b0, 1'b0);
    manual_reset = 1'b1;
    @(negedge clk_sys);
    manual_reset = 1'b0;
    check("log pulse", 12'h1, {11'h0, log_p | dao_top_i.track_reset_log_ff});
    cyc(2);
    check("count clr", 12'h0, count);
    check("users gone", 12'h0, {11'h0, aux_relay[1]});
    wait_idle();
    do_req(1'b1, 11'h006, 1'b0, 1'b1, 1'b1);
    $display("tracking test done");
  endtask : t_track

  task automatic t_out;
    cfg[1].fire_select = 1'b1;
    aux_zero_v_pin = 2'h0;
    cyc(40);
    check("fire hold", 12'h2, {10'h0, relay});
    aux_zero_v_pin = 2'h1;
    cyc(12);
    check("fire end", 12'h0, {11'h0, relay[1]});
    cfg[1].interlock = 1'b1;
    aux_zero_v_pin = 2'h3;
    press_cmd = 2'h2;
    cyc(10);
    check("interlock", 12'h0, {11'h0, relay[1]});
    press_cmd = 2'h0;
    aux_zero_v_pin = 2'h1;
    alt_cfg = '0;
    cfg[1].relay_time = 10'h002;
    cyc(4);
    press_cmd = 2'h2;
    cyc(8);
    check("il relay", 12'h3, {10'h0, relay[1], oc_b[1]});
    press_cmd = 2'h0;
    open_cmd = 2'h2;
    cyc(40);
    check("il open", 12'h1, {11'h0, oc_b[1]});
    alt_cfg.tech_fault = 1'b1;
    alt_cfg.any_open = 1'b1;
    alt_cfg.aux_any = 1'b1;
    aux_normal = 2'h2;
    tamper_pin = 1'b1;
    cyc(8);
    check("any open", 12'h1, {11'h0, oc_b[0]});
    check("tech fault", 12'h1, {11'h0, oc_a[0]});
    check("aux any", 12'h1, {11'h0, aux_relay[0]});
    {tamper_pin, mains_fail} = 2'h1;
    cyc(6);
    check("mains fault", 12'h1, {11'h0, oc_a[0]});
    mains_fail = 1'b0;
    open_cmd = 2'h0;
    aux_normal = 2'h0;
    cyc(8);
    check("alt idle", 12'h0, {9'h0, oc_a[0], oc_b[0], aux_relay[0]});
    $display("output test done");
  endtask : t_out

  // ==========================================
  // Clock, watchdog and main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end

  initial
  begin
    reset_n = 1'b0;
    {open_cmd, press_cmd, guest_key_pin, aux_normal, oc_a_norm, oc_b_norm} = '0;
    aux_zero_v_pin = 2'h1;
    {tamper_pin, mains_fail, manual_reset, apb_en, ulim_en} = '0;
    {limit_a, limit_b} = '0;
    pin_len_cfg = 4'h4;
    alt_cfg = '0;
    req = '0;
    for (int i = 0; i < 2; i++)
    begin
      cfg[i] = '0;
      cfg[i].push_button_en = 1'b1;
    end
    cyc(3);
    check("reset pin_len", 12'h4, {8'h0, pin_len});
    check("reset admin_len", 12'h6, {8'h0, admin_len});
    reset_n = 1'b1;
    wait_idle();
    t_pin();
    t_door();
    t_buzz();
    t_track();
    t_out();
    finish_test();
  end
endmodule : dao_top_test
